//--- verilog/asl_alert_select.sv
// alert configuration register and alert pin control
// Summary of operation
// - highest enabled source among bits 15..11 wins
// - shunt above limit raises alert
// - shunt below limit raises alert
// - bus above limit raises alert
// - bus below limit raises alert
// - power above limit raises alert
// - conversion done flag raises alert when enabled
// - register at 06h, bits 9..5 zero, reset zero
// - alert active low unless polarity bit set
// - latch holds alert until register read
// - source flag set on alert, cleared per mode
// - conversion flag set on completion, cleared single-shot
`timescale 1ns/10ps
`default_nettype none
module asl_alert_select (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [15:0] reg_wdata_in,
   output logic      [15:0] reg_rdata_out,
   input  wire logic [15:0] shunt_in,
   input  wire logic [15:0] bus_in,
   input  wire logic [15:0] power_in,
   input  wire logic [15:0] limit_in,
   input  wire logic        result_valid_in,
   input  wire logic        conv_complete_in,
   input  wire logic        single_shot_in,
   input  wire logic        config_wr_clear_in,
   input  wire logic        math_overflow_in,
   output logic             alert_o_out,
   output logic             alert_oe_out
);
   import asl_pkg::*;

   logic [5:0]  enables;
   logic        alert_active_level;
   logic        alert_latch_select;
   logic        alert_source_flag;
   logic        conversion_done_flag;
   logic        math_overflow_flag;
   logic        alert_pin_active;
   logic        cfg_read;
   logic        cfg_write;
   logic        eval;
   logic        fault;
   asl_src_t    src;
   logic        shunt_over_limit_en;
   logic        shunt_under_limit_en;
   logic        bus_over_limit_en;
   logic        bus_under_limit_en;
   logic        power_over_limit_en;
   logic        conv_done_alert_en;

   // the register index is decoded for read strobe, write strobe and readback alike
   function automatic logic cfg_hit(input logic [7:0] addr);
      return addr == ALERT_CONFIG_ADDR;
   endfunction : cfg_hit

   // readback word built from the field positions; unused bits stay zero
   function automatic logic [15:0] cfg_word(input logic [5:0] src_en,
                                            input logic       src_flag,
                                            input logic       done_flag,
                                            input logic       math_flag,
                                            input logic       level_sel,
                                            input logic       latch_sel);
      logic [15:0] word;
      word                                    = 16'h0000;
      word[SHUNT_OVER_BIT:CONV_DONE_EN_BIT]   = src_en;
      word[ALERT_FLAG_BIT]                    = src_flag;
      word[CONV_FLAG_BIT]                     = done_flag;
      word[MATH_OVERFLOW_BIT]                 = math_flag;
      word[ACTIVE_LEVEL_BIT]                  = level_sel;
      word[LATCH_SEL_BIT]                     = latch_sel;
      return word;
   endfunction : cfg_word

   assign cfg_read  = reg_rd_in && cfg_hit(reg_addr_in);
   assign cfg_write = reg_wr_in && cfg_hit(reg_addr_in);

   // bits 15..11 pick the limit source, bit 10 adds the conversion alert on top
   assign shunt_over_limit_en  = enables[5];
   assign shunt_under_limit_en = enables[4];
   assign bus_over_limit_en    = enables[3];
   assign bus_under_limit_en   = enables[2];
   assign power_over_limit_en  = enables[1];
   assign conv_done_alert_en   = enables[0];

   // priority pick of the limit source; only one limit compare can run at a time
   always_comb begin
      if (shunt_over_limit_en)       src = ASL_SRC_SHUNT_OVER;
      else if (shunt_under_limit_en) src = ASL_SRC_SHUNT_UNDER;
      else if (bus_over_limit_en)    src = ASL_SRC_BUS_OVER;
      else if (bus_under_limit_en)   src = ASL_SRC_BUS_UNDER;
      else if (power_over_limit_en)  src = ASL_SRC_POWER_OVER;
      else                           src = ASL_SRC_NONE;
   end

   asl_compare u_compare (
      .clk_in          (clk_in),
      .rstn_in         (rstn_in),
      .src_in          (src),
      .result_valid_in (result_valid_in),
      .shunt_in        (shunt_in),
      .bus_in          (bus_in),
      .power_in        (power_in),
      .limit_in        (limit_in),
      .eval_out        (eval),
      .fault_out       (fault)
   );

   // writable configuration bits
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         enables            <= ALERT_CONFIG_RESET[15:10];
         alert_active_level <= ALERT_CONFIG_RESET[ACTIVE_LEVEL_BIT];
         alert_latch_select <= ALERT_CONFIG_RESET[LATCH_SEL_BIT];
      end else if (cfg_write) begin
         enables            <= reg_wdata_in[15:10];
         alert_active_level <= reg_wdata_in[ACTIVE_LEVEL_BIT];
         alert_latch_select <= reg_wdata_in[LATCH_SEL_BIT];
      end
   end

   // source flag: a new fault wins over a read clear
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         alert_source_flag <= 1'b0;
      end else if (eval && fault) begin
         alert_source_flag <= 1'b1;
      end else if (alert_latch_select) begin
         if (cfg_read) alert_source_flag <= 1'b0;
      end else if (eval) begin
         alert_source_flag <= 1'b0;
      end
   end

   // completion sets; single-shot clears on read or config write
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         conversion_done_flag <= 1'b0;
      end else if (conv_complete_in) begin
         conversion_done_flag <= 1'b1;
      end else if (single_shot_in && (cfg_read || config_wr_clear_in)) begin
         conversion_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         math_overflow_flag <= 1'b0;
      end else if (conv_complete_in) begin
         math_overflow_flag <= math_overflow_in;
      end
   end

   // pin follows flags; latch holds, transparent releases
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         alert_pin_active <= 1'b0;
      end else begin
         alert_pin_active <= alert_source_flag || (conv_done_alert_en && conversion_done_flag);
      end
   end

   // open collector can only sink: the driven value is low in both polarities
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         alert_o_out <= 1'b0;
      end else begin
         alert_o_out <= 1'b0;
      end
   end

   // active low sinks while asserted; active high sinks while idle and lets the
   // pull-up signal the alert, so a released wire never reads as the wrong state
   assign alert_oe_out = alert_pin_active ^ alert_active_level;

   // readback with bits 9..5 as zero
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= 16'h0000;
      end else if (reg_rd_in) begin
         if (cfg_hit(reg_addr_in)) begin
            reg_rdata_out <= cfg_word(enables, alert_source_flag, conversion_done_flag,
                                      math_overflow_flag, alert_active_level,
                                      alert_latch_select);
         end else begin
            reg_rdata_out <= 16'h0000;
         end
      end
   end
endmodule : asl_alert_select
`default_nettype wire

//--- verilog/asl_pkg.sv
// package of constants for the alert source select logic
package asl_pkg;
   localparam int unsigned ALERT_CONFIG_OFFSET = 8'h06;
   localparam logic [7:0]  ALERT_CONFIG_ADDR   = 8'h06;
   localparam logic [15:0] ALERT_CONFIG_RESET  = 16'h0000;
   localparam int unsigned SHUNT_OVER_BIT      = 15;
   localparam int unsigned SHUNT_UNDER_BIT     = 14;
   localparam int unsigned BUS_OVER_BIT        = 13;
   localparam int unsigned BUS_UNDER_BIT       = 12;
   localparam int unsigned POWER_OVER_BIT      = 11;
   localparam int unsigned CONV_DONE_EN_BIT    = 10;
   localparam int unsigned ALERT_FLAG_BIT      = 4;
   localparam int unsigned CONV_FLAG_BIT       = 3;
   localparam int unsigned MATH_OVERFLOW_BIT   = 2;
   localparam int unsigned ACTIVE_LEVEL_BIT    = 1;
   localparam int unsigned LATCH_SEL_BIT       = 0;
   // bits that software may write: enables, polarity, latch select
   localparam logic [15:0] WRITE_MASK          = 16'hFC03;
   typedef enum logic [2:0] {
      ASL_SRC_NONE,
      ASL_SRC_SHUNT_OVER,
      ASL_SRC_SHUNT_UNDER,
      ASL_SRC_BUS_OVER,
      ASL_SRC_BUS_UNDER,
      ASL_SRC_POWER_OVER
   } asl_src_t;
endpackage : asl_pkg

//--- verilog/asl_compare.sv
// limit comparison for the selected alert source
`timescale 1ns/10ps
`default_nettype none
module asl_compare (
   input  wire logic                 clk_in,
   input  wire logic                 rstn_in,
   input  wire asl_pkg::asl_src_t    src_in,
   input  wire logic                 result_valid_in,
   input  wire logic [15:0]          shunt_in,
   input  wire logic [15:0]          bus_in,
   input  wire logic [15:0]          power_in,
   input  wire logic [15:0]          limit_in,
   output logic                      eval_out,
   output logic                      fault_out
);
   import asl_pkg::*;
   logic hit;

   // shunt is signed, bus and power unsigned
   always_comb begin
      case (src_in)
         ASL_SRC_SHUNT_OVER:  hit = $signed(shunt_in) > $signed(limit_in);
         ASL_SRC_SHUNT_UNDER: hit = $signed(shunt_in) < $signed(limit_in);
         ASL_SRC_BUS_OVER:    hit = bus_in > limit_in;
         ASL_SRC_BUS_UNDER:   hit = bus_in < limit_in;
         ASL_SRC_POWER_OVER:  hit = power_in > limit_in;
         default:             hit = 1'b0;
      endcase
   end

   // one evaluation per completed result
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         eval_out  <= 1'b0;
         fault_out <= 1'b0;
      end else begin
         eval_out <= result_valid_in;
         if (result_valid_in) begin
            fault_out <= hit;
         end
      end
   end
endmodule : asl_compare
`default_nettype wire

//--- verification/asl_host_mon.sv
// host side model: pull-up and level sense on the alert wire
`timescale 1ns/10ps
`default_nettype none
module asl_host_mon (
   input  wire logic alert_o_in,
   input  wire logic alert_oe_in,
   output logic      level_out
);
   // a released open-collector wire floats up to the pull-up, never to the last value
   assign level_out = alert_oe_in ? alert_o_in : 1'b1;
endmodule : asl_host_mon
`default_nettype wire

//--- verification/asl_props.sv
// concurrent checks on the alert select ports
`timescale 1ns/10ps
`default_nettype none
module asl_props (
   input wire logic        clk_in,
   input wire logic        rstn_in,
   input wire logic [7:0]  reg_addr_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic [15:0] shunt_in,
   input wire logic [15:0] bus_in,
   input wire logic [15:0] power_in,
   input wire logic [15:0] limit_in,
   input wire logic        result_valid_in,
   input wire logic        conv_complete_in,
   input wire logic        alert_o_out,
   input wire logic        alert_oe_out
);
   logic [15:0] en;
   logic [5:0]  e;
   logic        rd6, sg, sl, bg, bl, pg, wire_lvl, act;
   assign rd6 = reg_rd_in && reg_addr_in == 8'h06;
   assign e   = en[15:10];
   assign sg  = $signed(shunt_in) > $signed(limit_in);
   assign sl  = $signed(shunt_in) < $signed(limit_in);
   assign bg  = bus_in > limit_in;
   assign bl  = bus_in < limit_in;
   assign pg  = power_in > limit_in;
   // level on the pulled-up wire; the alert is asserted when it equals the polarity bit
   assign wire_lvl = alert_oe_out ? alert_o_out : 1'b1;
   assign act      = wire_lvl == en[1];
   // shadow of the writable bits, so checks know which source is armed
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in)
         en <= 16'h0000;
      else if (reg_wr_in && reg_addr_in == 8'h06)
         en <= reg_wdata_in & 16'hFC03;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   property hit(c);
      result_valid_in && c |-> ##3 act;
   endproperty
   shunt_over_a: assert property (hit(e == 6'h20 && sg)) else $error("no shunt over");
   shunt_under_a: assert property (hit(e == 6'h10 && sl)) else $error("no shunt under");
   bus_over_a: assert property (hit(e == 6'h08 && bg)) else $error("no bus over");
   bus_under_a: assert property (hit(e == 6'h04 && bl)) else $error("no bus under");
   power_over_a: assert property (hit(e == 6'h02 && pg)) else $error("no power over");
   src_priority_a: assert property (result_valid_in && e == 6'h30 && !en[0] && !sg
      |-> ##3 !act) else $error("lower source won");
   alert_level_a: assert property (alert_oe_out |-> !alert_o_out)
      else $error("wire driven high");
   latch_hold_a: assert property (en[0] && act && !rd6 && !$past(rd6)
      |=> act) else $error("latch lost");
   read_data_a: assert property (rd6 |=> reg_rdata_out[15:5] == {$past(e), 5'h00})
      else $error("bad read");
   read_other_a: assert property (reg_rd_in && !rd6 |=> reg_rdata_out == 16'h0000)
      else $error("other addr");
   conv_alert_a: assert property (conv_complete_in && en[10] |-> ##2 act)
      else $error("no conv alert");
   cover property (rd6 && en[0] && act);
   cover property (act && en[1]);
   cover property (conv_complete_in && en[10]);
endmodule : asl_props
bind asl_alert_select asl_props u_props (.clk_in, .rstn_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
   .reg_wdata_in, .reg_rdata_out, .shunt_in, .bus_in, .power_in, .limit_in, .result_valid_in,
   .conv_complete_in, .alert_o_out, .alert_oe_out);
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the alert select block
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        clk_in = 0, rstn_in = 0, wr = 0, rd = 0, rv = 0, cc = 0, ss = 0, cw = 0, ov = 0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wd = 16'h0000, sh = 16'h0000, bu = 16'h0000, pw = 16'h0000, lim = 16'h0100;
   logic [15:0] rdata;
   logic        ao, aoe, lvl;
   int          n_errors = 0, n_tests = 0;
   always #5 clk_in = ~clk_in;
   asl_alert_select dut (.clk_in, .rstn_in, .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_wdata_in(wd), .reg_rdata_out(rdata), .shunt_in(sh), .bus_in(bu), .power_in(pw),
      .limit_in(lim), .result_valid_in(rv), .conv_complete_in(cc), .single_shot_in(ss),
      .config_wr_clear_in(cw), .math_overflow_in(ov), .alert_o_out(ao), .alert_oe_out(aoe));
   asl_host_mon host (.alert_o_in(ao), .alert_oe_in(aoe), .level_out(lvl));
   task automatic chk(input logic [15:0] s, input logic [15:0] x);
      n_tests++;
      if (s !== x) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, x);
      end
   endtask : chk
   task automatic nx(input int n);
      repeat (n) @(negedge clk_in);
   endtask : nx
   task automatic pulse(ref logic s);
      nx(1);
      s = 1;
      nx(1);
      s = 0;
   endtask : pulse
   task automatic wreg(input logic [15:0] d);
      addr = 8'h06;
      wd = d;
      pulse(wr);
   endtask : wreg
   // read data stands from the read edge until the next read
   task automatic rreg(input logic [7:0] a);
      addr = a;
      pulse(rd);
      nx(1);
   endtask : rreg
   // comparison lands three edges after the result strobe
   task automatic res(input logic [47:0] v);
      {sh, bu, pw} = v;
      pulse(rv);
      nx(3);
   endtask : res
   task automatic t_regs();
      rreg(8'h06);
      chk(rdata, 16'h0000);
      wreg(16'hFFFF);
      rreg(8'h06);
      chk(rdata, 16'hFC03);
      rreg(8'h05);
      chk(rdata, 16'h0000);
   endtask : t_regs
   task automatic t_srcs();
      logic [47:0] f [5] = '{48'h0200_0100_0100, 48'hFF00_0100_0100, 48'h0100_0200_0100,
                             48'h0100_0050_0100, 48'h0100_0100_8000};
      for (int i = 0; i < 5; i++) begin
         wreg(16'h8000 >> i);
         res(f[i]);
         chk(aoe, 1);
         chk(lvl, 0);
         rreg(8'h06);
         chk(rdata, (16'h8000 >> i) | 16'h0010);
         res(48'h0100_0100_0100);
         chk({aoe, lvl}, 2'b01);
      end
   endtask : t_srcs
   task automatic t_prio();
      wreg(16'hC000);
      res(48'h0000_0100_0100);
      chk(aoe, 0);
   endtask : t_prio
   task automatic t_latch();
      wreg(16'h8003);
      nx(1);
      chk({aoe, lvl}, 2'b10);
      res(48'h0200_0100_0100);
      res(48'h0100_0100_0100);
      chk({aoe, lvl}, 2'b01);
      rreg(8'h06);
      chk(rdata, 16'h8013);
      nx(1);
      chk({aoe, lvl}, 2'b10);
   endtask : t_latch
   task automatic t_conv();
      wreg(16'h0400);
      ss = 1;
      ov = 1;
      pulse(cc);
      nx(3);
      chk(aoe, 1);
      rreg(8'h06);
      chk(rdata, 16'h040C);
      chk(aoe, 0);
      rreg(8'h06);
      chk(rdata, 16'h0404);
      pulse(cc);
      pulse(cw);
      rreg(8'h06);
      chk(rdata, 16'h0404);
      ss = 0;
      pulse(cc);
      rreg(8'h06);
      chk(rdata, 16'h040C);
      rreg(8'h06);
      chk(rdata, 16'h040C);
   endtask : t_conv
   task automatic test_done();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   initial begin
      nx(5);
      rstn_in = 1;
      t_regs();
      t_srcs();
      t_prio();
      t_latch();
      t_conv();
      test_done();
   end
   initial begin
      #20000;
      n_errors++;
      test_done();
   end
endmodule : tb
`default_nettype wire
